/* verilog/sdl_deser.sv */
// Deserializer lock core with its word FIFO and pin synchronizer.
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sdl_params.svh"

// ****************************************************************
// Pin synchronizer
// ****************************************************************
module sdl_sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A bit moves only when the last two stages agree, so a settling
   // first stage can never leak a glitch into the core.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= '0;
      end else begin
         q_o <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & q_o);
      end
   end
endmodule // sdl_sync3

// ****************************************************************
// Word FIFO
// ****************************************************************
module sdl_fifo #(
   parameter int W = 24,
   parameter int D = 8
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 clr_i,
   // Fill side
   input  wire logic                 in_valid_i,
   output logic                      in_ready_o,
   input  wire logic [W-1:0]         in_data_i,
   // Drain side
   output logic                      out_valid_o,
   input  wire logic                 out_ready_i,
   output logic      [W-1:0]         out_data_o,
   output logic      [$clog2(D):0]   level_o
);
   localparam int AW = $clog2(D);

   logic [W-1:0]  mem [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          wr;
   logic          rd;

   assign in_ready_o  = cnt_q != (AW+1)'(D);
   assign out_valid_o = cnt_q != '0;
   assign out_data_o  = mem[rd_q];
   assign level_o     = cnt_q;
   assign wr          = in_valid_i & in_ready_o;
   assign rd          = out_valid_o & out_ready_i;

   always_ff @(posedge clk_i) begin
      if (wr) begin
         mem[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clr_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (wr) begin
            wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
         end
         if (rd) begin
            rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
         end
         if (wr && !rd) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (rd && !wr) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // sdl_fifo

// ****************************************************************
// Lock core
// ****************************************************************
module sdl_deser
   import sdl_pkg::*;
#(
   parameter int OVS         = `SDL_OVS,
   parameter int LOCK_FRAMES = `SDL_LOCK_FRAMES,
   parameter int FIFO_DEPTH  = `SDL_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Serial line and control pins
   input  wire logic        serial_in_pos_i,
   input  wire logic        serial_in_neg_i,
   input  wire logic        out_enable_i,
   input  wire logic        out_edge_select_i,
   input  wire logic        rx_powerdown_n_i,
   input  wire logic        tie_low_input_i,
   // Parallel side
   output logic [23:0]      parallel_out_o,
   output logic             parallel_out_oe_o,
   output logic             recovered_clock_o,
   output logic             recovered_clock_oe_o,
   output logic             link_locked_o
);
   localparam int NB        = `SDL_FRAME_BITS;
   localparam int FRAME_CYC = NB * OVS;
   localparam int HALF_CYC  = FRAME_CYC / 2;
   localparam int PW        = $clog2(OVS);
   localparam int BW        = $clog2(NB);
   localparam int CW        = $clog2(FRAME_CYC);
   localparam int LW        = $clog2(LOCK_FRAMES) + 1;
   localparam int FL        = $clog2(FIFO_DEPTH) + 1;

   sdl_pins_type  pin_s;
   sdl_state_type st_q;
   logic [PW-1:0] ph_q;
   logic          prev_q;
   logic [NB-1:0] sh_q;
   logic [BW-1:0] bc_q;
   logic [LW-1:0] good_q;
   logic [CW-1:0] rc_q;
   logic          ctrl_q;
   logic          ovf_q;
   logic [15:0]   loss_q;
   logic          ack_q;
   logic [31:0]   dat_q;
   logic          line_bit;
   logic          run;
   logic          samp;
   logic [NB-1:0] frame_w;
   logic          frame_end;
   logic          frame_ok;
   logic          pll_lock;
   logic          push;
   logic          loss_ev;
   logic          launch;
   logic          lock_d;
   logic          f_in_rdy;
   logic          f_valid;
   logic          pop;
   logic [23:0]   f_data;
   logic [FL-1:0] f_level;
   logic          req;

   // ****************************************************************
   // Pin capture
   // ****************************************************************
   sdl_sync3 #(
      .W ($bits(sdl_pins_type))
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({serial_in_pos_i, serial_in_neg_i, out_enable_i,
               out_edge_select_i, rx_powerdown_n_i, tie_low_input_i}),
      .q_o   (pin_s)
   );

   // A floating or undriven pair reads as equal legs and decodes as a
   // steady zero, which holds no rising edge to lock onto.
   assign line_bit = pin_s.pos & ~pin_s.neg;
   assign run      = pin_s.pwr_n & ctrl_q;

   // ****************************************************************
   // Bit recovery
   // ****************************************************************
   // The phase counter realigns on every line transition and samples
   // mid-bit, so no reference clock is needed.
   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         ph_q   <= '0;
         prev_q <= 1'b0;
      end else begin
         prev_q <= line_bit;
         if (line_bit != prev_q) begin
            ph_q <= PW'(1);
         end else if (ph_q == PW'(OVS-1)) begin
            ph_q <= '0;
         end else begin
            ph_q <= ph_q + 1'b1;
         end
      end
   end

   assign samp    = run && (ph_q == PW'(OVS/2));
   assign frame_w = {sh_q[NB-2:0], line_bit};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh_q <= '0;
      end else if (samp) begin
         sh_q <= frame_w;
      end
   end

   // ****************************************************************
   // Frame check and lock search
   // ****************************************************************
   assign frame_end = samp && (st_q != st_hunt) && (bc_q == BW'(NB-1));
   assign frame_ok  = frame_w[`SDL_F_CLK1] && !frame_w[`SDL_F_CLK0]
                      && (frame_w[`SDL_F_DCA] ==
                          ^frame_w[`SDL_F_DMSB:`SDL_F_DCB]);
   assign pll_lock  = st_q == st_locked;
   assign push      = frame_end && pll_lock && frame_ok;
   assign loss_ev   = frame_end && pll_lock && !frame_ok;

   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         st_q   <= st_hunt;
         bc_q   <= '0;
         good_q <= '0;
      end else if (samp) begin
         case (st_q)
            // Any live data shows the embedded rising edge.
            st_hunt: begin
               if (!sh_q[0] && line_bit) begin
                  st_q   <= st_check;
                  bc_q   <= BW'(1);
                  good_q <= '0;
               end
            end
            st_check: begin
               if (bc_q == BW'(NB-1)) begin
                  bc_q <= '0;
                  if (!frame_ok) begin
                     st_q <= st_hunt;
                  end else if (good_q == LW'(LOCK_FRAMES-1)) begin
                     st_q <= st_locked;
                  end else begin
                     good_q <= good_q + 1'b1;
                  end
               end else begin
                  bc_q <= bc_q + 1'b1;
               end
            end
            st_locked: begin
               if (bc_q == BW'(NB-1)) begin
                  bc_q <= '0;
                  if (!frame_ok) begin
                     st_q <= st_hunt;
                  end
               end else begin
                  bc_q <= bc_q + 1'b1;
               end
            end
            default: begin
               st_q <= st_hunt;
            end
         endcase
      end
   end

   // ****************************************************************
   // Word buffer
   // ****************************************************************
   // Draining stalls while outputs are disabled; once full, new words
   // are dropped and flagged because the line itself cannot pause.
   sdl_fifo #(
      .W (`SDL_WORD_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .clr_i       (!pll_lock),
      .in_valid_i  (push),
      .in_ready_o  (f_in_rdy),
      .in_data_i   (frame_w[`SDL_F_DMSB:`SDL_F_DLSB] ^
                    {`SDL_WORD_W{frame_w[`SDL_F_DCB]}}),
      .out_valid_o (f_valid),
      .out_ready_i (pop),
      .out_data_o  (f_data),
      .level_o     (f_level)
   );

   // ****************************************************************
   // Parallel output stage
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i || !pll_lock) begin
         rc_q <= '0;
      end else if (rc_q == CW'(FRAME_CYC-1)) begin
         rc_q <= '0;
      end else begin
         rc_q <= rc_q + 1'b1;
      end
   end

   assign launch = pll_lock && (pin_s.edge_sel ? (rc_q == '0)
                                : (rc_q == CW'(HALF_CYC)));
   assign pop    = launch && f_valid && pin_s.oe;
   assign lock_d = pll_lock && (link_locked_o || (launch && f_valid));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         parallel_out_o <= '0;
      end else if (pop) begin
         parallel_out_o <= f_data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         recovered_clock_o <= 1'b0;
      end else begin
         recovered_clock_o <= pll_lock && (rc_q < CW'(HALF_CYC));
      end
   end

   // Lock is shown with the first launched word, and the enables follow
   // lock so that nothing is driven before the link is up.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link_locked_o        <= 1'b0;
         parallel_out_oe_o    <= 1'b0;
         recovered_clock_oe_o <= 1'b0;
      end else begin
         link_locked_o        <= lock_d;
         parallel_out_oe_o    <= lock_d && pin_s.oe;
         recovered_clock_oe_o <= lock_d && pin_s.oe;
      end
   end

   // ****************************************************************
   // Register access
   // ****************************************************************
   assign req      = wb_cyc_i && wb_stb_i && !ack_q;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `SDL_CTRL_RST;
      end else if (req && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == `SDL_ADR_CTRL) begin
         ctrl_q <= wb_dat_i[`SDL_CTRL_LINK];
      end
   end

   // A new overflow or loss in the clearing cycle is kept.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovf_q <= 1'b0;
      end else if (push && !f_in_rdy) begin
         ovf_q <= 1'b1;
      end else if (req && wb_we_i && wb_sel_i[1]
                   && wb_adr_i == `SDL_ADR_STATUS
                   && wb_dat_i[`SDL_ST_OVF]) begin
         ovf_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loss_q <= '0;
      end else if (req && wb_we_i && wb_adr_i == `SDL_ADR_LOSS) begin
         loss_q <= loss_ev ? 16'h0001 : 16'h0000;
      end else if (loss_ev && loss_q != 16'hffff) begin
         loss_q <= loss_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= '0;
      end else if (req) begin
         if (wb_adr_i == `SDL_ADR_CTRL) begin
            dat_q <= {31'h0, ctrl_q};
         end else if (wb_adr_i == `SDL_ADR_STATUS) begin
            dat_q <= {21'h0, pin_s.tie, ovf_q, 4'(f_level),
                      st_q, pll_lock, link_locked_o};
         end else if (wb_adr_i == `SDL_ADR_LOSS) begin
            dat_q <= {16'h0, loss_q};
         end else begin
            dat_q <= '0;
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_float_unlocked: assert property (
      !link_locked_o |-> !parallel_out_oe_o && !recovered_clock_oe_o)
      else $error("outputs driven while unlocked");

   chk_lock_follows: assert property (
      link_locked_o |-> $past(pll_lock))
      else $error("lock flag high without loop lock");

   chk_lock_first: assert property (
      $rose(link_locked_o) |-> $past(launch && f_valid))
      else $error("lock rose without a launched word");

   chk_lock_count: assert property (
      $rose(pll_lock) |-> $past(frame_ok && samp)
         && $past(good_q) == LW'(LOCK_FRAMES-1))
      else $error("lock taken without enough good frames");

   chk_miss_drop: assert property (
      loss_ev |=> st_q == st_hunt ##1 !link_locked_o)
      else $error("missed edge did not drop lock");

   chk_no_early: assert property (
      !link_locked_o |-> $stable(parallel_out_o))
      else $error("word delivered before lock");

   chk_edge_sel: assert property (
      pop |=> recovered_clock_o == $past(pin_s.edge_sel))
      else $error("word launched on wrong clock edge");

   chk_oe_gate: assert property (
      link_locked_o && !$past(pin_s.oe) |-> !parallel_out_oe_o)
      else $error("outputs driven while disabled");

   chk_wb_ack: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for two cycles");

endmodule // sdl_deser
`default_nettype wire

/* common/sdl_params.svh */
// Offsets, field positions, reset values and counts for the lock core.
// How it works
// - link_locked is high only while locked; else low, with outputs floated.
// - Each frame yields one 24-bit parallel_out word and recovered_clock.
// - Lock needs no reference clock and works for any data.
// - Serializer locks first, then deserializer; no data moves before that.
// - The serializer floats its line until locked; an idle line never locks.
// - link_locked stays low, outputs floated, until locked to the stream.
// - No training pattern; ordinary data carries the embedded clock edge.
// - Lock needs the rising embedded edge and good data; time may vary.
// - link_locked rises in the cycle the first valid word appears.
// - out_edge_select high: launch on rising recovered_clock; low: falling.
// - out_enable low floats both outputs while the loop stays locked.
// - One missed embedded edge drops link_locked and restarts the search.
// - link_locked stays driven and follows lock while outputs float.
`ifndef SDL_PARAMS_SVH
`define SDL_PARAMS_SVH

`define SDL_OVS         4
`define SDL_FRAME_BITS  28
`define SDL_LOCK_FRAMES 4
`define SDL_FIFO_DEPTH  8
`define SDL_WORD_W      24

`define SDL_ADR_CTRL    8'h00
`define SDL_ADR_STATUS  8'h04
`define SDL_ADR_LOSS    8'h08
`define SDL_CTRL_LINK   0
`define SDL_ST_OVF      9
`define SDL_CTRL_RST    1'b1

`define SDL_F_CLK1      27
`define SDL_F_DMSB      26
`define SDL_F_DLSB      3
`define SDL_F_DCB       2
`define SDL_F_DCA       1
`define SDL_F_CLK0      0

`endif

/* common/sdl_pkg.sv */
// Types shared by the lock core.
package sdl_pkg;

   typedef enum logic [2:0] {
      st_hunt   = 3'b001,
      st_check  = 3'b010,
      st_locked = 3'b100
   } sdl_state_type;

   typedef struct packed {
      logic pos;
      logic neg;
      logic oe;
      logic edge_sel;
      logic pwr_n;
      logic tie;
   } sdl_pins_type;

endpackage

/* sim/sdl_ser_model.sv */
// Behavioural serializer that feeds framed random words to the lock core.
`timescale 1ns/1ps
`default_nettype none

module sdl_ser_model #(
   parameter int OVS = 4
) (
   // Clock and controls
   input  wire logic        clk_i,
   input  wire logic        drive_i,
   input  wire logic        bad_clk0_i,
   input  wire logic        bad_dca_i,
   // Line legs
   output logic             pos_o,
   output logic             neg_o,
   // Report of each word put on the line
   output logic             sent_o,
   output logic [23:0]      word_o
);
   logic [27:0] frame_q = 28'h0;
   logic [27:0] nf;
   logic [23:0] w;
   logic [23:0] s;
   logic        dcb;
   logic        idle_q = 1'b0;
   logic [4:0]  bit_q = 5'h0;
   int          ph_q = 0;

   initial begin
      pos_o = 1'b0;
      neg_o = 1'b0;
      sent_o = 1'b0;
      word_o = 24'h0;
   end

   always @(posedge clk_i) begin
      sent_o <= 1'b0;
      idle_q <= ~idle_q;
      if (!drive_i) begin
         // A released line must never look steady, so both legs toggle.
         pos_o <= idle_q;
         neg_o <= idle_q;
         ph_q <= 0;
         bit_q <= 5'h0;
      end else begin
         if (ph_q == 0 && bit_q == 5'h0) begin
            w = 24'($urandom);
            dcb = 1'($urandom);
            s = dcb ? ~w : w;
            nf = {1'b1, s, dcb, ^s ^ dcb ^ bad_dca_i, bad_clk0_i};
            frame_q <= nf;
            word_o <= w;
            sent_o <= 1'b1;
         end else begin
            nf = frame_q;
         end
         pos_o <= nf[5'h1b - bit_q];
         neg_o <= ~nf[5'h1b - bit_q];
         ph_q <= (ph_q == OVS - 1) ? 0 : ph_q + 1;
         if (ph_q == OVS - 1) begin
            bit_q <= (bit_q == 5'h1b) ? 5'h0 : bit_q + 5'h1;
         end
      end
   end
endmodule // sdl_ser_model

`default_nettype wire

/* sim/serdes_link_lock_init_bench.sv */
// Self-checking bench for the deserializer lock core.
`timescale 1ns/1ps
`default_nettype none

module serdes_link_lock_init_bench;
   localparam int OVS = 4;
   localparam int FRM = OVS * 28;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h0;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic        pos, neg, sent, po_oe, rc, rc_oe, ll;
   logic [23:0] word, po;
   logic        out_en = 1'b1;
   logic        sel = 1'b1;
   logic        pwr_n = 1'b1;
   logic        drv = 1'b0;
   logic        bad_clk0 = 1'b0;
   logic        bad_dca = 1'b0;
   logic        ll_q = 1'b0;
   logic        loose = 1'b1;
   logic [23:0] po_q = 24'h0;
   logic [23:0] sentq[$];
   int          bad_count = 0;
   int          comparisons = 0;

   always #20 clk_i = ~clk_i;

   sdl_ser_model #(.OVS(OVS)) i_sdl_ser_model (
      .clk_i(clk_i), .drive_i(drv), .bad_clk0_i(bad_clk0),
      .bad_dca_i(bad_dca), .pos_o(pos), .neg_o(neg), .sent_o(sent),
      .word_o(word));

   sdl_deser #(.OVS(OVS)) i_sdl_deser (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .serial_in_pos_i(pos), .serial_in_neg_i(neg), .out_enable_i(out_en),
      .out_edge_select_i(sel), .rx_powerdown_n_i(pwr_n),
      .tie_low_input_i(1'b0),
      .parallel_out_o(po), .parallel_out_oe_o(po_oe),
      .recovered_clock_o(rc), .recovered_clock_oe_o(rc_oe),
      .link_locked_o(ll));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic bus(input logic we, input logic [7:0] a,
                      input logic [31:0] wd, input logic [3:0] s,
                      output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= wd;
      wb_sel <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1);
      rd = wb_rdat;
      check(32'(n), 32'h2);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask

   // Expected STATUS bits 4:0: one-hot state, loop lock, lock flag.
   function automatic logic [4:0] exp_lock_bits(input logic locked);
      return {(locked ? 3'h4 : 3'h1), locked, locked};
   endfunction

   // Lock time depends on the data, so only a generous bound is used.
   task automatic wait_ll(input logic v, input int lim);
      int n;
      n = 0;
      while (ll !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
   endtask

   // ****************************************************************
   // Output monitor
   // ****************************************************************
   always @(posedge clk_i) begin : mon
      int   skip;
      logic hit;
      if (sent) sentq.push_back(word);
      if (!rst_i) begin
         if (!ll) check(32'({po_oe, rc_oe}), 32'h0);
         if (ll && !ll_q) check(32'({po_oe, rc_oe}), 32'h3);
         if (po_oe && po !== po_q) begin
            check(32'(rc), 32'(sel));
            skip = 0;
            hit = 1'b0;
            while (sentq.size() > 0 && !hit) begin
               hit = (sentq.pop_front() === po);
               if (!hit) skip++;
            end
            check(32'(hit), 32'h1);
            if (!loose) check(32'(skip), 32'h0);
         end
      end
      ll_q <= ll;
      po_q <= po;
   end

   initial begin : watchdog
      repeat (80000) @(posedge clk_i);
      bad_count++;
      stop_test();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin : main
      logic [31:0] d;
      void'($urandom(32'h42af));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(1'b0, 8'h00, 32'h0, 4'hf, d);
      check(d, 32'h1);
      bus(1'b1, 8'h00, 32'h0, 4'he, d);
      bus(1'b0, 8'h00, 32'h0, 4'hf, d);
      check(d, 32'h1);
      bus(1'b0, 8'h08, 32'h0, 4'hf, d);
      check(d, 32'h0);
      bus(1'b1, 8'h0c, $urandom, 4'hf, d);
      bus(1'b0, 8'h0c, 32'h0, 4'hf, d);
      check(d, 32'h0);
      repeat (6 * FRM) @(posedge clk_i);
      check(32'(ll), 32'h0);
      drv <= 1'b1;
      wait_ll(1'b1, 3000);
      check(32'(ll), 32'h1);
      bus(1'b0, 8'h04, 32'h0, 4'hf, d);
      check(32'(d[4:0]), 32'(exp_lock_bits(1'b1)));
      check(32'(d[10]), 32'h0);
      repeat (3 * FRM) @(posedge clk_i);
      loose <= 1'b0;
      repeat (FRM * (6 + $urandom_range(4))) @(posedge clk_i);
      out_en <= 1'b0;
      repeat (12 * FRM) @(posedge clk_i);
      check(32'({po_oe, rc_oe}), 32'h0);
      check(32'(ll), 32'h1);
      bus(1'b0, 8'h04, 32'h0, 4'hf, d);
      check(32'(d[9:5]), 32'h18);
      loose <= 1'b1;
      out_en <= 1'b1;
      repeat (10 * FRM) @(posedge clk_i);
      bus(1'b1, 8'h00, 32'h0, 4'h1, d);
      wait_ll(1'b0, 50);
      check(32'(ll), 32'h0);
      bus(1'b1, 8'h04, 32'h200, 4'hd, d);
      bus(1'b0, 8'h04, 32'h0, 4'hf, d);
      check(32'(d[9]), 32'h1);
      check(32'(d[4:0]), 32'(exp_lock_bits(1'b0)));
      bus(1'b1, 8'h04, 32'h200, 4'h2, d);
      bus(1'b1, 8'h08, $urandom, 4'hf, d);
      bus(1'b0, 8'h04, 32'h0, 4'hf, d);
      check(32'(d[9]), 32'h0);
      bus(1'b1, 8'h00, 32'h1, 4'h1, d);
      wait_ll(1'b1, 3000);
      check(32'(ll), 32'h1);
      repeat (4 * FRM) @(posedge clk_i);
      loose <= 1'b0;
      repeat (4 * FRM) @(posedge clk_i);
      // One frame with a missing clock edge.
      bad_clk0 <= 1'b1;
      repeat (FRM) @(posedge clk_i);
      bad_clk0 <= 1'b0;
      loose <= 1'b1;
      wait_ll(1'b0, 2 * FRM);
      check(32'(ll), 32'h0);
      wait_ll(1'b1, 3000);
      check(32'(ll), 32'h1);
      bus(1'b0, 8'h08, 32'h0, 4'hf, d);
      check(d, 32'h1);
      bad_dca <= 1'b1;
      wait_ll(1'b0, 3 * FRM);
      repeat (20 * FRM) @(posedge clk_i);
      check(32'(ll), 32'h0);
      bad_dca <= 1'b0;
      pwr_n <= 1'b0;
      repeat (3 * FRM) @(posedge clk_i);
      check(32'(ll), 32'h0);
      sel <= 1'b0;
      pwr_n <= 1'b1;
      wait_ll(1'b1, 3000);
      check(32'(ll), 32'h1);
      repeat (4 * FRM) @(posedge clk_i);
      loose <= 1'b0;
      repeat (FRM * (5 + $urandom_range(4))) @(posedge clk_i);
      stop_test();
   end
endmodule // serdes_link_lock_init_bench

`default_nettype wire
